// ==== core/message_doorbell_endpoint.sv ====
// receive side of the message and doorbell endpoint
`timescale 1ns/10ps
`include "msg_doorbell_params.svh"
module message_doorbell_endpoint
  import msg_doorbell_pkg::*;
#(
  parameter int ID_W     = 8,
  parameter int DB_DEPTH = 8,
  parameter int RQ_DEPTH = 4
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            arst_n,
  // apb register port
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // inbound request header
  input  wire logic            hdr_valid,
  output logic                 hdr_ready,
  input  wire code_t           hdr_ftype,
  input  wire logic [ID_W-1:0] hdr_src,
  input  wire logic [7:0]      hdr_tid,
  input  wire logic [15:0]     hdr_info,
  input  wire logic [3:0]      hdr_msglen,
  input  wire logic [3:0]      hdr_msgseg,
  input  wire code_t           hdr_ssize,
  input  wire logic [1:0]      hdr_mbox,
  input  wire logic [1:0]      hdr_letter,
  input  wire logic [5:0]      hdr_len_dw,
  // inbound payload doublewords
  input  wire logic            pl_valid,
  output logic                 pl_ready,
  input  wire logic [63:0]     pl_data,
  input  wire logic            pl_last,
  // local memory write port
  output logic                 mem_valid,
  input  wire logic            mem_ready,
  output logic      [31:0]     mem_addr,
  output logic      [63:0]     mem_wdata,
  output logic      [7:0]      mem_be,
  output logic                 mem_snoop,
  // outbound response
  output logic                 rsp_valid,
  input  wire logic            rsp_ready,
  output logic [ID_W-1:0]      rsp_dest,
  output logic      [7:0]      rsp_tid,
  output code_t                rsp_status,
  output code_t                rsp_trans,
  // processor notification
  output logic                 notify
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [5:0] ssize_dw(input code_t c);
    ssize_dw = 6'h01 << (c - `SSIZE_MIN);
  endfunction : ssize_dw

  function automatic logic [4:0] ones(input logic [15:0] m);
    ones = '0;
    for (int i = 0; i < 16; i++) begin
      ones = ones + {4'h0, m[i]};
    end
  endfunction : ones

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam int DBW = $clog2(DB_DEPTH);
  localparam int RQW = $clog2(RQ_DEPTH);
  rx_state_t        state_reg, state_next;
  logic [2:0]       ctrl_reg;
  logic [31:0]      base_reg [4];
  logic             done_reg;
  logic             notify_reg;
  logic [ID_W+15:0] db_mem [DB_DEPTH];
  logic [DBW:0]     db_cnt_reg;
  logic [DBW-1:0]   db_wp_reg, db_rp_reg;
  logic [ID_W+15:0] rq_mem [RQ_DEPTH];
  logic [RQW:0]     rq_cnt_reg;
  logic [RQW-1:0]   rq_wp_reg, rq_rp_reg;
  logic [3:0]       mb_busy_reg;
  logic [1:0]       mb_let_reg [4];
  logic [ID_W-1:0]  mb_src_reg [4];
  logic [15:0]      mb_mask_reg [4];
  logic [ID_W-1:0]  cur_src_reg;
  logic [7:0]       cur_tid_reg;
  logic [3:0]       cur_len_reg, cur_seg_reg;
  logic [1:0]       cur_mbox_reg, cur_let_reg;
  logic             cur_msg_reg;
  code_t            cur_st_reg;
  logic [31:0]      cur_addr_reg;
  logic             mv_reg;
  logic [31:0]      ma_reg;
  logic [63:0]      md_reg;

  // ---------------------------------------------------------------
  // header decode
  // ---------------------------------------------------------------
  wire        hdr_fire  = hdr_valid && hdr_ready;
  wire        is_db     = hdr_ftype == `FT_DB;
  wire        is_msg    = hdr_ftype == `FT_MSG;
  wire        ss_ok     = hdr_ssize >= `SSIZE_MIN && hdr_ssize <= `SSIZE_MAX;
  wire [5:0]  std_dw    = ssize_dw(hdr_ssize);
  wire        last_seg  = hdr_msgseg == hdr_msglen;
  // only the final segment may be short; no empty payload exists
  wire        len_ok    = hdr_msgseg <= hdr_msglen && hdr_len_dw != 6'h00 &&
                          (last_seg ? hdr_len_dw <= std_dw : hdr_len_dw == std_dw);
  wire        db_full   = db_cnt_reg == (DBW+1)'(DB_DEPTH);
  wire        rq_full   = rq_cnt_reg == (RQW+1)'(RQ_DEPTH);
  // one letter per mailbox at a time; others must come back later
  wire        mb_clash  = mb_busy_reg[hdr_mbox] &&
                          (mb_let_reg[hdr_mbox] != hdr_letter ||
                           mb_src_reg[hdr_mbox] != hdr_src);
  wire        bad       = !ctrl_reg[`CTRL_EN] || !(is_db || is_msg) ||
                          (is_msg && !(ss_ok && len_ok));
  wire code_t hdr_st    = bad ? `ST_ERROR :
                          (is_db && db_full) || (is_msg && mb_clash) ? `ST_RETRY :
                          `ST_DONE;
  // segment offset is index times standard size, order-free
  wire [31:0] seg_off   = 32'(hdr_msgseg) * (32'(std_dw) * `DW_BYTES);
  wire [31:0] hdr_addr  = base_reg[hdr_mbox] + seg_off;
  wire        db_push   = hdr_fire && is_db && hdr_st == `ST_DONE;

  // ---------------------------------------------------------------
  // request sequencing
  // ---------------------------------------------------------------
  // header intake waits for the previous packet's local work and for room in the response queue
  assign hdr_ready = state_reg == S_IDLE;
  assign pl_ready  = (state_reg == S_WRITE && (!mv_reg || mem_ready)) ||
                     state_reg == S_DRAIN;
  wire pl_fire   = pl_valid && pl_ready;
  wire rq_push   = state_reg == S_RESP && !mv_reg && !rq_full;
  wire [15:0] new_mask = mb_mask_reg[cur_mbox_reg] | (16'h0001 << cur_seg_reg);
  wire msg_end   = rq_push && cur_msg_reg && cur_st_reg == `ST_DONE &&
                   ones(new_mask) == 5'(cur_len_reg) + 5'h01;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE:  if (hdr_fire) begin
        // doorbells carry no payload
        state_next = !is_msg ? S_RESP :
                     hdr_st == `ST_DONE ? S_WRITE : S_DRAIN;
      end
      // refused messages are consumed, never dropped silently
      S_WRITE: if (pl_fire && pl_last) begin
        state_next = S_RESP;
      end
      S_DRAIN: if (pl_fire && pl_last) begin
        state_next = S_RESP;
      end
      S_RESP:  if (rq_push) begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_src_reg  <= '0;
      cur_tid_reg  <= '0;
      cur_len_reg  <= '0;
      cur_seg_reg  <= '0;
      cur_mbox_reg <= '0;
      cur_let_reg  <= '0;
      cur_msg_reg  <= 1'b0;
      cur_st_reg   <= `ST_DONE;
      cur_addr_reg <= '0;
    end else if (hdr_fire) begin
      cur_src_reg  <= hdr_src;
      cur_tid_reg  <= hdr_tid;
      cur_len_reg  <= hdr_msglen;
      cur_seg_reg  <= hdr_msgseg;
      cur_mbox_reg <= hdr_mbox;
      cur_let_reg  <= hdr_letter;
      cur_msg_reg  <= is_msg;
      cur_st_reg   <= hdr_st;
      cur_addr_reg <= hdr_addr;
    end else if (pl_fire && state_reg == S_WRITE) begin
      cur_addr_reg <= cur_addr_reg + `DW_BYTES;
    end
  end

  // ---------------------------------------------------------------
  // local memory write stage
  // ---------------------------------------------------------------
  // little-endian local memory swaps the big-endian doubleword
  wire [63:0] swapped;
  for (genvar b = 0; b < 8; b++) begin : g_swap
    assign swapped[8*b +: 8] = pl_data[8*(7-b) +: 8];
  end
  wire [63:0] wr_data = ctrl_reg[`CTRL_SWAP] ? swapped : pl_data;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mv_reg <= 1'b0;
      ma_reg <= '0;
      md_reg <= '0;
    end else if (pl_fire && state_reg == S_WRITE) begin
      mv_reg <= 1'b1;
      ma_reg <= cur_addr_reg;
      md_reg <= wr_data;
    end else if (mem_ready) begin
      mv_reg <= 1'b0;
    end
  end

  assign mem_valid = mv_reg;
  assign mem_addr  = ma_reg;
  assign mem_wdata = md_reg;
  // payloads are whole doublewords, so every lane carries data
  assign mem_be    = 8'hff;
  assign mem_snoop = ctrl_reg[`CTRL_SNOOP];

  // ---------------------------------------------------------------
  // mailbox tracking
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mb_busy_reg <= '0;
      for (int i = 0; i < 4; i++) begin
        mb_let_reg[i]  <= '0;
        mb_src_reg[i]  <= '0;
        mb_mask_reg[i] <= '0;
      end
    end else if (rq_push && cur_msg_reg && cur_st_reg == `ST_DONE) begin
      mb_busy_reg[cur_mbox_reg] <= !msg_end;
      mb_let_reg[cur_mbox_reg]  <= cur_let_reg;
      mb_src_reg[cur_mbox_reg]  <= cur_src_reg;
      mb_mask_reg[cur_mbox_reg] <= msg_end ? 16'h0000 : new_mask;
    end
  end

  // ---------------------------------------------------------------
  // response queue
  // ---------------------------------------------------------------
  // a short queue lets intake run while the fabric is slow
  wire rq_pop = rsp_valid && rsp_ready;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rq_cnt_reg <= '0;
      rq_wp_reg  <= '0;
      rq_rp_reg  <= '0;
    end else begin
      rq_cnt_reg <= rq_cnt_reg + (RQW+1)'(rq_push) - (RQW+1)'(rq_pop);
      rq_wp_reg  <= rq_wp_reg + RQW'(rq_push);
      rq_rp_reg  <= rq_rp_reg + RQW'(rq_pop);
    end
  end

  // message answers name the segment, doorbell answers the identifier
  wire [7:0] rsp_id = cur_msg_reg ? {cur_let_reg, cur_mbox_reg, cur_seg_reg}
                                  : cur_tid_reg;
  always_ff @(posedge clk) begin
    if (rq_push) begin
      rq_mem[rq_wp_reg] <= {cur_src_reg, rsp_id, cur_st_reg,
                            cur_msg_reg ? `TR_MSG : `TR_NODATA};
    end
  end

  wire [ID_W+15:0] rq_head = rq_mem[rq_rp_reg];
  assign rsp_valid  = rq_cnt_reg != '0;
  assign rsp_dest   = rsp_valid ? rq_head[ID_W+15:16] : '0;
  assign rsp_tid    = rsp_valid ? rq_head[15:8] : '0;
  assign rsp_status = rsp_valid ? rq_head[7:4] : `ST_DONE;
  assign rsp_trans  = rsp_valid ? rq_head[3:0] : `TR_NODATA;

  // ---------------------------------------------------------------
  // doorbell queue and registers
  // ---------------------------------------------------------------
  wire apb_wr  = psel && penable && pwrite;
  wire apb_rd  = psel && penable && !pwrite;
  wire hit_mb  = paddr[11:4] == 8'(`MBASE_OFS >> 4) && paddr[1:0] == 2'b00;
  wire mapped  = paddr == `CTRL_OFS || paddr == `STATUS_OFS ||
                 paddr == `DBPOP_OFS || hit_mb;
  wire db_pop  = apb_rd && paddr == `DBPOP_OFS && db_cnt_reg != '0;
  wire [ID_W+15:0] db_head = db_mem[db_rp_reg];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      db_cnt_reg <= '0;
      db_wp_reg  <= '0;
      db_rp_reg  <= '0;
    end else begin
      db_cnt_reg <= db_cnt_reg + (DBW+1)'(db_push) - (DBW+1)'(db_pop);
      db_wp_reg  <= db_wp_reg + DBW'(db_push);
      db_rp_reg  <= db_rp_reg + DBW'(db_pop);
    end
  end

  always_ff @(posedge clk) begin
    if (db_push) begin
      db_mem[db_wp_reg] <= {hdr_src, hdr_info};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= '0;
      for (int i = 0; i < 4; i++) begin
        base_reg[i] <= '0;
      end
    end else if (apb_wr && paddr == `CTRL_OFS) begin
      ctrl_reg <= pwdata[2:0];
    end else if (apb_wr && hit_mb) begin
      base_reg[paddr[3:2]] <= pwdata;
    end
  end

  // a completion arriving with the clear still sets the flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_reg   <= 1'b0;
      notify_reg <= 1'b0;
    end else begin
      done_reg   <= msg_end ||
                    (done_reg && !(apb_wr && paddr == `STATUS_OFS && pwdata[`ST_DONE_BIT]));
      notify_reg <= msg_end || db_push;
    end
  end
  assign notify = notify_reg;

  wire [31:0] status_val = {19'h0_0000, done_reg, mb_busy_reg,
                            8'(db_cnt_reg)};
  wire [31:0] db_val     = {db_cnt_reg != '0, 7'h00, 8'(db_head[ID_W+15:16]),
                            db_head[15:0]};
  assign prdata  = !apb_rd ? 32'h0000_0000 :
                   paddr == `CTRL_OFS   ? {29'h0000_0000, ctrl_reg} :
                   paddr == `STATUS_OFS ? status_val :
                   paddr == `DBPOP_OFS  ? db_val :
                   hit_mb ? base_reg[paddr[3:2]] : 32'h0000_0000;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_msg_taken;
    hdr_fire && is_msg && hdr_st == `ST_DONE;
  endsequence

  chk_status_codes: assert property (rsp_valid |-> rsp_status inside
    {`ST_DONE, `ST_RETRY, `ST_ERROR}) else $error("bad status code");
  chk_db_no_payload: assert property (hdr_fire && is_db |=>
    state_reg == S_RESP && !pl_ready) else $error("doorbell took payload");
  chk_retry_full: assert property (hdr_fire && ctrl_reg[`CTRL_EN] && is_db &&
    db_full |=> cur_st_reg == `ST_RETRY) else $error("no retry on full queue");
  chk_ssize_error: assert property (hdr_fire && is_msg && !ss_ok |=>
    cur_st_reg == `ST_ERROR) else $error("reserved size accepted");
  chk_seg_address: assert property (s_msg_taken |=> cur_addr_reg ==
    $past(base_reg[hdr_mbox]) + 32'($past(hdr_msgseg)) * 32'($past(std_dw)) * `DW_BYTES)
    else $error("segment address wrong");
  chk_intake_free: assert property (state_reg == S_RESP && !mv_reg && !rq_full |=>
    hdr_ready) else $error("intake blocked");
  chk_answer_sent: assert property (rq_push |=> rsp_valid ##0
    state_reg == S_IDLE) else $error("answer missing");
  chk_db_queued: assert property (db_push && !db_pop |=>
    db_cnt_reg == $past(db_cnt_reg) + 1'b1) else $error("doorbell not queued");
  chk_notify_cause: assert property (notify |-> $past(msg_end) ||
    $past(db_push)) else $error("notify without cause");
endmodule : message_doorbell_endpoint

// ==== inc/msg_doorbell_params.svh ====
// constants for the message and doorbell endpoint
// What this block does
// - doorbell responses echo the requester's transaction identifier; message responses carry letter, mailbox and segment.
// - every accepted request gets exactly one response after its work ends.
// - successful requests are answered with a done status.
// - busy mailbox or full doorbell queue is answered with retry.
// - unrecoverable errors are answered with an error status.
// - doorbells carry only an info field and no payload.
// - accepted doorbells queue sender and info for the processor.
// - a message has at most sixteen segments.
// - payload lengths are whole doublewords.
// - segment index and count place segments in any arrival order.
// - mailbox field picks the mailbox; letter keeps messages apart.
// - all but the final segment carry exactly the standard size.
// - address is mailbox base plus segment index times standard size.
// - optional cache snoop while writing cacheable mailbox memory.
// - payloads are big-endian doublewords; little-endian side swaps bytes.
// - small quantities sit in natural byte lanes of the doubleword.
// - accepting input waits on the output port only when the response queue is full.
// - packets are never dropped to free resources.
// - any arrival order of outstanding transactions is handled.
// - status codes: done 0000, retry 0011, error 0111.
// - standard size 1001 is 8 bytes, doubling up to 1110.
// - doorbell format type 1010, message format type 1011.
// - response transaction 0000 without payload, 0001 for messages.
`ifndef MSG_DOORBELL_PARAMS_SVH
`define MSG_DOORBELL_PARAMS_SVH
`define CTRL_OFS    12'h000
`define STATUS_OFS  12'h004
`define DBPOP_OFS   12'h008
`define MBASE_OFS   12'h010
`define ST_DONE     4'h0
`define ST_RETRY    4'h3
`define ST_ERROR    4'h7
`define FT_DB       4'ha
`define FT_MSG      4'hb
`define TR_NODATA   4'h0
`define TR_MSG      4'h1
`define SSIZE_MIN   4'h9
`define SSIZE_MAX   4'he
`define DW_BYTES    32'h0000_0008
`define CTRL_EN     0
`define CTRL_SWAP   1
`define CTRL_SNOOP  2
`define ST_DONE_BIT 12
`endif

// ==== inc/msg_doorbell_pkg.sv ====
// types for the message and doorbell endpoint
package msg_doorbell_pkg;
  typedef enum logic [1:0] {S_IDLE, S_WRITE, S_DRAIN, S_RESP} rx_state_t;
  typedef logic [3:0] code_t;
endpackage : msg_doorbell_pkg

// ==== tb/remote_requester.sv ====
// far-side requester model: sends headers and payload beats, takes responses
`timescale 1ns/10ps
`include "msg_doorbell_params.svh"
module remote_requester (
  // clock and pacing
  input  wire logic        clk,
  input  wire logic        slow,
  // request side
  output logic             hdr_valid,
  input  wire logic        hdr_ready,
  output logic [57:0]      hdr,
  output logic             pl_valid,
  input  wire logic        pl_ready,
  output logic [63:0]      pl_data,
  output logic             pl_last,
  // response side
  output logic             rsp_ready
);
  int seed = 69;
  initial begin
    hdr_valid = 1'b0;
    hdr       = '0;
    pl_valid  = 1'b0;
    pl_data   = '0;
    pl_last   = 1'b0;
  end
  // a slow requester takes a response only now and then
  always @(posedge clk) begin
    rsp_ready <= !slow || (($random(seed) & 3) == 0);
  end
  // ---------------------------------------------------------------
  // one request packet, held until taken
  // ---------------------------------------------------------------
  task automatic send(input logic [57:0] h_in, input logic [31:0] tag);
    int n;
    @(posedge clk);
    hdr       <= h_in;
    hdr_valid <= 1'b1;
    do @(posedge clk); while (!hdr_ready);
    hdr_valid <= 1'b0;
    hdr       <= ~h_in;  // released fields show no stale value
    if (h_in[57:54] == `FT_MSG) begin
      for (n = 0; n < int'(h_in[5:0]); n++) begin
        pl_data  <= {tag, 32'(n)};
        pl_last  <= (n == int'(h_in[5:0]) - 1);
        pl_valid <= 1'b1;
        do @(posedge clk); while (!pl_ready);
      end
      pl_valid <= 1'b0;
      pl_data  <= ~pl_data;
    end
  endtask : send
endmodule : remote_requester

// ==== tb/tb_message_doorbell_endpoint.sv ====
// self-checking bench for the message and doorbell endpoint
`timescale 1ns/10ps
`include "msg_doorbell_params.svh"
module tb_message_doorbell_endpoint
  import msg_doorbell_pkg::*;
;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  logic hdr_valid, hdr_ready, pl_valid, pl_ready, pl_last, mem_valid, mem_ready, mem_snoop;
  logic rsp_valid, rsp_ready, notify;
  logic [57:0] hdr;
  logic [63:0] pl_data, mem_wdata;
  logic [31:0] mem_addr;
  logic [7:0]  mem_be, rsp_dest, rsp_tid;
  code_t       rsp_status, rsp_trans;
  logic [23:0] rq[$];
  logic [95:0] memq[$];
  logic [23:0] dbq[$];
  int error_cnt = 0, comparisons = 0, cyc = 0, notify_cnt = 0, seed, i;
  logic [7:0]  s, t;
  logic [15:0] inf;
  logic [3:0]  mlen;
  logic        swp;
  message_doorbell_endpoint i_message_doorbell_endpoint (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr_ftype(hdr[57:54]),
    .hdr_src(hdr[53:46]), .hdr_tid(hdr[45:38]), .hdr_info(hdr[37:22]),
    .hdr_msglen(hdr[21:18]), .hdr_msgseg(hdr[17:14]), .hdr_ssize(hdr[13:10]),
    .hdr_mbox(hdr[9:8]), .hdr_letter(hdr[7:6]), .hdr_len_dw(hdr[5:0]),
    .pl_valid(pl_valid), .pl_ready(pl_ready), .pl_data(pl_data), .pl_last(pl_last),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_snoop(mem_snoop),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_dest(rsp_dest), .rsp_tid(rsp_tid),
    .rsp_status(rsp_status), .rsp_trans(rsp_trans), .notify(notify));
  remote_requester i_remote_requester (
    .clk(clk), .slow(slow), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .hdr(hdr),
    .pl_valid(pl_valid), .pl_ready(pl_ready), .pl_data(pl_data), .pl_last(pl_last),
    .rsp_ready(rsp_ready));
  // ---------------------------------------------------------------
  // clock, monitors, memory pacing, hang guard
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rsp_valid && rsp_ready) rq.push_back({rsp_dest, rsp_tid, rsp_status, rsp_trans});
    if (mem_valid && mem_ready) begin
      memq.push_back({mem_addr, mem_wdata});
      chk_v(mem_be, 96'hff);
    end
    if (notify === 1'b1) notify_cnt++;
    mem_ready <= !slow || $random(seed) & 1;
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic chk_v(input logic [95:0] got, input logic [95:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_v
  // wait bounded for the next response, then compare it whole
  task automatic chk_rsp(input logic [7:0] d, input logic [7:0] tid, input code_t st,
                         input code_t tr);
    int w;
    for (w = 0; w < 500 && rq.size() == 0; w++) @(posedge clk);
    chk_v((rq.size() == 0) ? 'x : rq.pop_front(), {d, tid, st, tr});
  endtask : chk_rsp
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [57:0] hd(code_t ft, logic [7:0] sr, logic [7:0] tid,
    logic [15:0] nf, logic [3:0] ln, logic [3:0] sg, code_t ss, logic [1:0] lt, logic [5:0] nd);
    return {ft, sr, tid, nf, ln, sg, ss, 2'd2, lt, nd};
  endfunction : hd
  // expected little-endian view of a big-endian doubleword
  function automatic logic [63:0] bsw(logic [63:0] v);
    for (int k = 0; k < 8; k++) bsw[8*k +: 8] = v[8*(7-k) +: 8];
  endfunction : bsw
  function automatic logic [31:0] ea(logic [3:0] sg, code_t ss, int n);
    return 32'h0000_3000 + 32'(sg) * (32'h0000_0008 << (ss - 4'h9)) + 32'(8 * n);
  endfunction : ea
  task automatic db(input code_t st);
    i_remote_requester.send(hd(`FT_DB, s, t, inf, 4'h0, 4'h0, 4'h9, 2'd0, 6'd0), 32'h0);
    chk_rsp(s, t, st, `TR_NODATA);
  endtask : db
  // message to mailbox 2; written beats must match address and data
  task automatic msg(input logic [1:0] lt, input logic [3:0] sg, input logic [5:0] nd,
                     input code_t ss, input code_t st);
    logic [31:0] tag;
    int n;
    tag = $random(seed);
    memq.delete();
    i_remote_requester.send(hd(`FT_MSG, 8'h5a, 8'h00, 16'h0000, mlen, sg, ss, lt, nd), tag);
    chk_rsp(8'h5a, {lt, 2'd2, sg}, st, `TR_MSG);
    chk_v(96'(memq.size()), (st == `ST_DONE) ? 96'(nd) : 96'h0);
    for (n = 0; n < memq.size(); n++)
      chk_v(memq[n], {ea(sg, ss, n), swp ? bsw({tag, 32'(n)}) : {tag, 32'(n)}});
  endtask : msg
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 69;
    arst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, slow, swp} = '0;
    repeat (16) @(posedge clk);
    chk_v({pready, hdr_ready, rsp_valid, notify, mem_valid}, 96'h18);
    arst_n <= 1'b1;
    {s, t, inf} = {8'h11, 8'h22, 16'h3344};
    db(`ST_ERROR);
    apb(1'b1, `CTRL_OFS, 32'h0000_0005);
    @(negedge clk);
    chk_v(mem_snoop, 96'h1);
    apb(1'b1, `MBASE_OFS + 12'h008, 32'h0000_3000);
    apb(1'b0, `MBASE_OFS + 12'h008, 32'h0);
    chk_v(q, 96'h3000);
    apb(1'b0, 12'h0fc, 32'h0);
    chk_v({e, q}, 96'h1_0000_0000);
    for (i = 0; i < 8; i++) begin
      {s, t, inf} = $random(seed);
      dbq.push_back({s, inf});
      db(`ST_DONE);
    end
    {s, t, inf} = $random(seed);
    db(`ST_RETRY);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk_v(q[7:0], 96'h8);
    for (i = 0; i < 8; i++) begin
      apb(1'b0, `DBPOP_OFS, 32'h0);
      chk_v(q, {1'b1, 7'h00, dbq.pop_front()});
    end
    db(`ST_DONE);
    i_remote_requester.send(hd(4'h5, s, t, inf, 4'h0, 4'h0, 4'h9, 2'd0, 6'd0), 32'h0);
    chk_rsp(s, t, `ST_ERROR, `TR_NODATA);
    chk_v(notify_cnt, 96'h9);
    mlen = 4'h5;
    msg(2'd1, 4'h0, 6'd1, 4'h8, `ST_ERROR);
    msg(2'd1, 4'h0, 6'd1, 4'hf, `ST_ERROR);
    msg(2'd1, 4'h6, 6'd4, 4'hb, `ST_ERROR);
    msg(2'd1, 4'h0, 6'd3, 4'hb, `ST_ERROR);
    msg(2'd1, 4'h2, 6'd4, 4'hb, `ST_DONE);
    msg(2'd2, 4'h0, 6'd4, 4'hb, `ST_RETRY);
    slow <= 1'b1;
    msg(2'd1, 4'h4, 6'd4, 4'hb, `ST_DONE);
    msg(2'd1, 4'h0, 6'd4, 4'hb, `ST_DONE);
    msg(2'd1, 4'h5, 6'd2, 4'hb, `ST_DONE);
    msg(2'd1, 4'h1, 6'd4, 4'hb, `ST_DONE);
    msg(2'd1, 4'h3, 6'd4, 4'hb, `ST_DONE);
    repeat (4) @(posedge clk);
    chk_v(notify_cnt, 96'ha);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk_v(q[12], 96'h1);
    apb(1'b1, `CTRL_OFS, 32'h0000_0007);
    swp = 1'b1;
    msg(2'd3, 4'h0, 6'd1, 4'h9, `ST_DONE);
    complete_run();
  end
endmodule : tb_message_doorbell_endpoint
